// ==== tpst_cfg.svh ====
`ifndef TPST_CFG_SVH
`define TPST_CFG_SVH

// =============================================================
// Register map (byte addresses, decoded on the low address byte)
`define TPST_ADDR_CTRL      32'h10000030
`define TPST_ADDR_COUNT     32'h10000034
`define TPST_ADDR_RELOAD    32'h01000038
`define TPST_DEC_LSB        0
`define TPST_DEC_MSB        7

// =============================================================
// Control register bit positions
`define TPST_BIT_IRQ_EN     7
`define TPST_BIT_FLAG       6
`define TPST_BIT_MODE       4
`define TPST_BIT_RUN        3
`define TPST_BIT_OE         2
`define TPST_BIT_PS_HI      1
`define TPST_BIT_PS_LO      0

// =============================================================
// Reset values
`define TPST_RST_CTRL       8'h00
`define TPST_RST_COUNT      4'h0
`define TPST_RST_RELOAD     4'h0
`define TPST_RST_BYTE       8'h00
`define TPST_RST_PRESC      10'h000

// =============================================================
// Prescaler tap masks: tick when the low bits of the divider are all ones
`define TPST_MASK_DIV16     10'h00f
`define TPST_MASK_DIV64     10'h03f
`define TPST_MASK_DIV256    10'h0ff
`define TPST_MASK_DIV1024   10'h3ff

// =============================================================
// Counter limits and documented timing
`define TPST_COUNT_ZERO     4'h0
`define TPST_MAX_DELAY_MS   512
`define TPST_SYSCLK_MHZ     32

`endif

// ==== tpst_down_counter.sv ====
`timescale 1ns/100ps
`include "tpst_cfg.svh"

module tpst_down_counter
#(
    parameter int WIDTH = 4
)
(
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             reset,
    // Control
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] loadValue,
    input  wire logic             decrement,
    // Status
    output      logic [WIDTH-1:0] value,
    output      logic             underflow
);

    tpst_pkg::tpst_cnt_state_t state;
    tpst_pkg::tpst_cnt_state_t next_state;

    always_comb
    begin
        next_state = state;
        // A host load never comes with a decrement, so a reload load must not mask the underflow
        underflow  = decrement && (state.value == `TPST_COUNT_ZERO);
        // Load has priority so a reload on the underflow edge is not lost
        if (load)
            next_state.value = loadValue;
        else if (decrement)
            next_state.value = state.value - 4'h1;
        value = state.value;
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
            state.value <= `TPST_RST_COUNT;
        else
            state <= next_state;
    end

endmodule // tpst_down_counter

// ==== tpst_host_model.sv ====
`timescale 1ns/100ps
module tpst_host_model
(
    // Clock
    input wire logic          mclk,
    // Bus toward the timer
    output tpst_pkg::tpst_bus_t bus,
    input wire logic [7:0]    dataOut
);
    initial bus = '{csN: 1'b1, rdN: 1'b1, weN: 1'b1, addr: 32'h0, wdata: 8'h00};
    // ==========================================
    // Released address and data lines show the inverse, not the last value
    task automatic release_bus();
        bus.csN   = 1'b1;
        bus.rdN   = 1'b1;
        bus.weN   = 1'b1;
        bus.addr  = ~bus.addr;
        bus.wdata = ~bus.wdata;
    endtask
    task automatic write(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        #1;
        bus.addr  = {24'h100000, a};
        bus.wdata = d;
        bus.csN   = 1'b0;
        bus.weN   = 1'b0;
        @(posedge mclk);
        #1;
        release_bus();
    endtask
    task automatic read(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        #1;
        bus.addr = {24'h100000, a};
        bus.csN  = 1'b0;
        bus.rdN  = 1'b0;
        @(posedge mclk);
        #1;
        d = dataOut;
        release_bus();
    endtask
endmodule // tpst_host_model

// ==== tpst_pkg.sv ====
package tpst_pkg;

    // =============================================================
    // Host bus inputs as sampled on mclk
    typedef struct packed {
        logic        csN;
        logic        rdN;
        logic        weN;
        logic [31:0] addr;
        logic [7:0]  wdata;
    } tpst_bus_t;

    typedef enum logic [1:0] {
        TPST_DIV16   = 2'h0,
        TPST_DIV64   = 2'h1,
        TPST_DIV256  = 2'h2,
        TPST_DIV1024 = 2'h3
    } tpst_presc_t;

    typedef enum logic {
        TPST_MODE_DELAY  = 1'b0,
        TPST_MODE_RELOAD = 1'b1
    } tpst_mode_t;

    // =============================================================
    // Control register layout
    typedef struct packed {
        logic        irqEnable;
        logic        underflowFlag;
        logic        spare;
        tpst_mode_t  mode;
        logic        countRun;
        logic        outputEnable;
        tpst_presc_t prescale;
    } tpst_ctrl_t;

    typedef struct packed {
        logic [9:0] divider;
    } tpst_presc_state_t;

    typedef struct packed {
        logic [3:0] value;
    } tpst_cnt_state_t;

    typedef struct packed {
        tpst_ctrl_t ctrl;
        logic [3:0] reload;
        logic       timerLevel;
        logic       pendingLevel;
        logic       delayArmed;
        logic       mPrev;
        logic       writePrev;
        logic [7:0] readData;
    } tpst_state_t;

endpackage

// ==== tpst_prescaler.sv ====
`timescale 1ns/100ps
`include "tpst_cfg.svh"

module tpst_prescaler
#(
    parameter int WIDTH = 10
)
(
    // Clock and reset
    input  wire logic                 mclk,
    input  wire logic                 reset,
    // Divider selection and output strobe
    input  wire tpst_pkg::tpst_presc_t sel,
    output      logic                 tick
);

    tpst_pkg::tpst_presc_state_t state;
    tpst_pkg::tpst_presc_state_t next_state;
    logic [WIDTH-1:0]            mask;

    always_comb
    begin
        next_state         = state;
        next_state.divider = state.divider + 10'h001;
        unique case (sel)
            tpst_pkg::TPST_DIV16:   mask = `TPST_MASK_DIV16;
            tpst_pkg::TPST_DIV64:   mask = `TPST_MASK_DIV64;
            tpst_pkg::TPST_DIV256:  mask = `TPST_MASK_DIV256;
            tpst_pkg::TPST_DIV1024: mask = `TPST_MASK_DIV1024;
        endcase
        tick = ((state.divider & mask) == mask);
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
            state.divider <= `TPST_RST_PRESC;
        else
            state <= next_state;
    end

endmodule // tpst_prescaler

// ==== tpst_sampling_timer.sv ====
`timescale 1ns/100ps
`include "tpst_cfg.svh"

module tpst_sampling_timer
#(
    parameter int CNT_WIDTH   = 4,
    parameter int PRESC_WIDTH = 10,
    parameter int OTHER_IRQS  = 3
)
(
    // Clock and reset
    input  wire logic                    mclk,
    input  wire logic                    reset,
    // Host register bus
    input  wire tpst_pkg::tpst_bus_t     bus,
    output      logic [7:0]              dataOut,
    output      logic                    dataOe_n,
    // LCD inversion signal and timer output
    input  wire logic                    lcdInvert,
    output      logic                    timerOut,
    // Shared interrupt request
    input  wire logic [OTHER_IRQS-1:0]   otherIrq,
    output      logic                    irqReq_n
);

    tpst_pkg::tpst_state_t state;
    tpst_pkg::tpst_state_t next_state;

    logic                 prescTick;
    logic                 cntLoad;
    logic [CNT_WIDTH-1:0] cntLoadValue;
    logic                 cntDec;
    logic [CNT_WIDTH-1:0] cntValue;
    logic                 underflow;
    logic                 readActive;
    logic                 writeActive;
    logic                 writeStrobe;
    logic                 selCtrl;
    logic                 selCount;
    logic                 selReload;
    logic                 mEdge;

    // =============================================================
    // Prescaler and counter
    tpst_prescaler
    #(
        .WIDTH (PRESC_WIDTH)
    )
    uPrescaler
    (
        .mclk  (mclk),
        .reset (reset),
        .sel   (state.ctrl.prescale),
        .tick  (prescTick)
    );

    tpst_down_counter
    #(
        .WIDTH (CNT_WIDTH)
    )
    uCounter
    (
        .mclk      (mclk),
        .reset     (reset),
        .load      (cntLoad),
        .loadValue (cntLoadValue),
        .decrement (cntDec),
        .value     (cntValue),
        .underflow (underflow)
    );

    // =============================================================
    // Bus decode
    always_comb
    begin
        readActive  = !bus.csN && !bus.rdN;
        writeActive = !bus.csN && !bus.weN;
        writeStrobe = writeActive && !state.writePrev;
        // Only the low address byte is decoded
        selCtrl     = bus.addr[`TPST_DEC_MSB:`TPST_DEC_LSB] == 8'(`TPST_ADDR_CTRL);
        selCount    = bus.addr[`TPST_DEC_MSB:`TPST_DEC_LSB] == 8'(`TPST_ADDR_COUNT);
        selReload   = bus.addr[`TPST_DEC_MSB:`TPST_DEC_LSB] == 8'(`TPST_ADDR_RELOAD);
        mEdge       = lcdInvert != state.mPrev;
    end

    // =============================================================
    // Counter control
    always_comb
    begin
        cntLoad      = 1'b0;
        cntLoadValue = state.reload;
        cntDec       = 1'b0;
        if (writeStrobe && selCount)
        begin
            cntLoad      = 1'b1;
            cntLoadValue = bus.wdata[CNT_WIDTH-1:0];
        end
        else if (state.ctrl.mode == tpst_pkg::TPST_MODE_DELAY)
        begin
            if (mEdge)
                cntLoad = 1'b1;
            else
                cntDec = state.ctrl.countRun && state.delayArmed && prescTick;
        end
        else
        begin
            cntDec = state.ctrl.countRun && prescTick;
            if (cntDec && cntValue == `TPST_COUNT_ZERO)
                cntLoad = 1'b1;
        end
    end

    // =============================================================
    // Register and output state
    always_comb
    begin
        next_state           = state;
        next_state.mPrev     = lcdInvert;
        next_state.writePrev = writeActive;

        if (writeStrobe && selCtrl)
        begin
            next_state.ctrl.irqEnable    = bus.wdata[`TPST_BIT_IRQ_EN];
            next_state.ctrl.mode         = tpst_pkg::tpst_mode_t'(bus.wdata[`TPST_BIT_MODE]);
            next_state.ctrl.countRun     = bus.wdata[`TPST_BIT_RUN];
            next_state.ctrl.outputEnable = bus.wdata[`TPST_BIT_OE];
            next_state.ctrl.prescale     = tpst_pkg::tpst_presc_t'(
                {bus.wdata[`TPST_BIT_PS_HI], bus.wdata[`TPST_BIT_PS_LO]});
            if (!bus.wdata[`TPST_BIT_FLAG])
                next_state.ctrl.underflowFlag = 1'b0;
        end
        if (writeStrobe && selReload)
            next_state.reload = bus.wdata[CNT_WIDTH-1:0];

        // Delay mode: capture new level, release on underflow
        if (state.ctrl.mode == tpst_pkg::TPST_MODE_DELAY && mEdge && !(writeStrobe && selCount))
        begin
            next_state.pendingLevel = lcdInvert;
            next_state.delayArmed   = 1'b1;
        end
        if (underflow)
        begin
            next_state.ctrl.underflowFlag = 1'b1;
            if (state.ctrl.mode == tpst_pkg::TPST_MODE_RELOAD)
                next_state.timerLevel = !state.timerLevel;
            else
            begin
                next_state.timerLevel = state.pendingLevel;
                next_state.delayArmed = 1'b0;
            end
        end

        if (readActive)
        begin
            next_state.readData = `TPST_RST_BYTE;
            if (selCtrl)
                next_state.readData = {state.ctrl.irqEnable, state.ctrl.underflowFlag, 1'b0,
                                       state.ctrl.mode, state.ctrl.countRun,
                                       state.ctrl.outputEnable, state.ctrl.prescale};
            else if (selCount)
                next_state.readData[CNT_WIDTH-1:0] = cntValue;
            else if (selReload)
                next_state.readData[CNT_WIDTH-1:0] = state.reload;
        end
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            state.ctrl         <= tpst_pkg::tpst_ctrl_t'(`TPST_RST_CTRL);
            state.reload       <= `TPST_RST_RELOAD;
            state.timerLevel   <= 1'b0;
            state.pendingLevel <= 1'b0;
            state.delayArmed   <= 1'b0;
            state.mPrev        <= 1'b0;
            state.writePrev    <= 1'b0;
            state.readData     <= `TPST_RST_BYTE;
        end
        else
            state <= next_state;
    end

    // =============================================================
    // Outputs
    always_comb
    begin
        dataOut  = state.readData;
        dataOe_n = !readActive;
        timerOut = state.ctrl.outputEnable && state.timerLevel;
        irqReq_n = !((state.ctrl.irqEnable && state.ctrl.underflowFlag) || (|otherIrq));
    end

endmodule // tpst_sampling_timer

// ==== tpst_sampling_timer_sva.sv ====
`timescale 1ns/100ps
module tpst_sampling_timer_sva
#(
    parameter int OTHER_IRQS = 3
)
(
    // Clock and reset
    input wire logic                  mclk,
    input wire logic                  reset,
    // Host register bus
    input wire tpst_pkg::tpst_bus_t   bus,
    input wire logic [7:0]            dataOut,
    input wire logic                  dataOe_n,
    // Timer pins
    input wire logic                  lcdInvert,
    input wire logic                  timerOut,
    input wire logic [OTHER_IRQS-1:0] otherIrq,
    input wire logic                  irqReq_n
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    // ==========================================
    // Bus steps
    sequence s_rd(a);
        !bus.csN && !bus.rdN && bus.addr[7:0] == a;
    endsequence
    sequence s_wr_ctrl;
        !bus.csN && !bus.weN && bus.addr[7:0] == 8'h30;
    endsequence
    sequence s_wr_irq_off;
        s_wr_ctrl ##0 (!bus.wdata[7] && otherIrq == 0);
    endsequence
    sequence s_irq_quiet;
        !irqReq_n && otherIrq == 0 && (bus.csN || bus.weN);
    endsequence
    // ==========================================
    // Properties
    a_irq_merge: assert property ((|otherIrq) |-> !irqReq_n)
        else $error("shared request not low for another source");
    a_irq_masked: assert property (s_wr_irq_off ##1 (otherIrq == 0) |-> irqReq_n)
        else $error("request raised while disabled");
    a_irq_holds: assert property (s_irq_quiet ##1 (otherIrq == 0) |-> !irqReq_n)
        else $error("request dropped without a write");
    a_out_off: assert property (s_wr_ctrl ##0 !bus.wdata[2] |=> !timerOut [*2])
        else $error("timer output not low when disabled");
    a_count_width: assert property (s_rd(8'h34) |=> dataOut[7:4] == 4'h0)
        else $error("count upper bits not zero");
    a_reload_width: assert property (s_rd(8'h38) |=> dataOut[7:4] == 4'h0)
        else $error("reload upper bits not zero");
    a_ctrl_spare: assert property (s_rd(8'h30) |=> !dataOut[5])
        else $error("spare control bit not zero");
    a_read_hold: assert property ((bus.csN || bus.rdN) |=> $stable(dataOut))
        else $error("read data moved outside a read");
    a_data_drive: assert property (dataOe_n == (bus.csN || bus.rdN))
        else $error("data enable wrong");
endmodule // tpst_sampling_timer_sva

bind tpst_sampling_timer tpst_sampling_timer_sva #(.OTHER_IRQS(OTHER_IRQS)) tpst_sampling_timer_sva_i (.mclk(mclk),
    .reset(reset), .bus(bus), .dataOut(dataOut), .dataOe_n(dataOe_n), .lcdInvert(lcdInvert),
    .timerOut(timerOut), .otherIrq(otherIrq), .irqReq_n(irqReq_n));

// ==== tpst_sampling_timer_tb.sv ====
`timescale 1ns/100ps
module tpst_sampling_timer_tb;
    logic                mclk = 1'b0;
    logic                reset = 1'b1;
    tpst_pkg::tpst_bus_t bus;
    logic [7:0]          dataOut;
    logic                dataOe_n;
    logic                lcdInvert = 1'b0;
    logic                timerOut;
    logic [2:0]          otherIrq = 3'h0;
    logic                irqReq_n;
    logic [7:0]          rd;
    int                  n;
    int                  mismatches = 0;
    int                  check_count = 0;
    always #5 mclk = ~mclk;
    tpst_sampling_timer tpst_sampling_timer_i (.mclk(mclk), .reset(reset), .bus(bus), .dataOut(dataOut),
        .dataOe_n(dataOe_n), .lcdInvert(lcdInvert), .timerOut(timerOut), .otherIrq(otherIrq), .irqReq_n(irqReq_n));
    tpst_host_model tpst_host_model_i (.mclk(mclk), .bus(bus), .dataOut(dataOut));
    // ==========================================
    // Shared tasks
    task automatic print_verdict();
        if (mismatches == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wait_out(input logic v, output int c);
        c = 0;
        while (timerOut !== v && c < 40000)
        begin
            @(posedge mclk);
            #1;
            c++;
        end
        if (c >= 40000)
        begin
            mismatches++;
            print_verdict();
        end
    endtask
    // ==========================================
    // Scenarios
    task automatic t_reset();
        for (int i = 0; i < 4; i++)
        begin
            tpst_host_model_i.read(8'h30 + 8'(4 * i), rd);
            check("reg", rd, 8'h00);
        end
        check("out", timerOut, 1'b0);
        check("irq", irqReq_n, 1'b1);
    endtask
    task automatic t_reload();
        logic [3:0] rl;
        for (int ps = 0; ps < 4; ps++)
        begin
            rl = (ps == 3) ? 4'hf : 4'h3;
            tpst_host_model_i.write(8'h38, {4'h0, rl});
            tpst_host_model_i.write(8'h34, 8'h00);
            tpst_host_model_i.write(8'h30, 8'h9c | 8'(ps));
            wait_out(~timerOut, n);
            wait_out(~timerOut, n);
            check("period", n, (rl + 1) * (16 << (2 * ps)));
            check("irq", irqReq_n, 1'b0);
            tpst_host_model_i.read(8'h30, rd);
            check("flag", rd, 8'hdc | 8'(ps));
            // Writing one to the flag leaves it set
            tpst_host_model_i.write(8'h30, 8'hdc | 8'(ps));
            check("keep", irqReq_n, 1'b0);
            tpst_host_model_i.write(8'h30, 8'h80 | 8'(ps));
            check("clear", irqReq_n, 1'b1);
        end
    endtask
    task automatic t_halt_oe();
        tpst_host_model_i.write(8'h34, 8'h05);
        repeat (300) @(posedge mclk);
        tpst_host_model_i.read(8'h34, rd);
        check("halt", rd, 8'h05);
        tpst_host_model_i.write(8'h38, 8'h00);
        tpst_host_model_i.write(8'h30, 8'h18);
        n = 0;
        // Long enough for several underflows toggling the hidden level
        repeat (160)
        begin
            @(posedge mclk);
            #1;
            if (timerOut !== 1'b0)
                n++;
        end
        check("oe", n, 0);
        tpst_host_model_i.read(8'h30, rd);
        check("flag", rd, 8'h58);
        check("masked", irqReq_n, 1'b1);
    endtask
    task automatic t_delay();
        tpst_host_model_i.write(8'h38, 8'h03);
        tpst_host_model_i.write(8'h30, 8'h8c);
        // Level left over from reload mode: line the M signal up with it first
        lcdInvert = timerOut;
        repeat (2) @(posedge mclk);
        #1;
        for (int i = 0; i < 2; i++)
        begin
            tpst_host_model_i.write(8'h30, 8'h8c);
            check("armed", irqReq_n, 1'b1);
            lcdInvert = ~lcdInvert;
            wait_out(lcdInvert, n);
            check("delay", n >= 48 && n <= 70, 1'b1);
            check("irq", irqReq_n, 1'b0);
        end
        tpst_host_model_i.write(8'h30, 8'h00);
    endtask
    task automatic t_irq();
        for (int i = 0; i < 3; i++)
        begin
            otherIrq = 3'(1 << i);
            @(posedge mclk);
            #1;
            check("merge", irqReq_n, 1'b0);
            otherIrq = 3'h0;
            @(posedge mclk);
            #1;
            check("idle", irqReq_n, 1'b1);
        end
    endtask
    initial
    begin
        repeat (6) @(posedge mclk);
        #1;
        reset = 1'b0;
        t_reset();
        t_reload();
        t_halt_oe();
        t_delay();
        t_irq();
        print_verdict();
    end
endmodule // tpst_sampling_timer_tb
